// ==== regulator_fault_interrupt_bank_test.sv ====
// Self-checking bench for the regulator fault interrupt bank.
// Assumes a 20 MHz clock and short debounce counts set through parameters.
`timescale 1ns/1ps
`default_nettype none
module regulator_fault_interrupt_bank_test;
  import rfib_pkg::*;
  localparam int OC = 8;
  localparam int SOV = 4;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic strap = 1'b1;
  logic rd_seen = 1'b0;
  rfib_src_t lvl = '0;
  rfib_src_t raw;
  rfib_req_t req = '0;
  logic [7:0] rdata;
  logic irq_n;
  logic [7:0] exp_q[$];
  logic [7:0] rnd = 8'h28;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;

  always #25 clk = ~clk;

  rfib_fault_src u_src (.level_i(lvl), .fault_raw_o(raw));
  rfib_bank #(.OC_DEB(OC), .SOV_DEB(SOV)) u_dut (.clk(clk), .arst_n(arst_n), .fault_raw_i(raw),
    .aux_supply_grounded_i(strap), .req_i(req), .rdata_o(rdata), .irq_out_n(irq_n));

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Pin follows registers updated at the edge, so look after the update settles
  task automatic irq_is(input logic e);
    #1;
    check({7'h00, irq_n}, {7'h00, e});
  endtask : irq_is

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr

  task automatic go(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) req <= '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge clk) req <= '0;
  endtask : go

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    go(1'b0, 1'b1, a, 8'h00);
  endtask : rd

  // Read data holds until the next read, which go() spaces two edges apart
  always @(posedge clk) begin
    if (rd_seen) begin
      #1;
      check(rdata, exp_q.pop_front());
    end
  end
  always @(posedge clk) rd_seen <= req.rd;

  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      report_and_stop();
    end
  end

  initial begin : main
    logic [7:0] a;
    logic [7:0] b;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    irq_is(1'b1);
    rd(ADDR_BUCK_STAT, 8'h00);
    rd(ADDR_BUCK_MASK, 8'h7f);
    rd(ADDR_BUCK_SENSE, 8'h00);
    rd(ADDR_SOV_STAT, 8'h04);
    rd(ADDR_SOV_MASK, 8'hc5);
    rd(ADDR_SOV_SENSE, 8'h00);
    rd(ADDR_LDO_STAT, 8'h00);
    rd(ADDR_LDO_MASK, 8'h3f);
    rd(ADDR_LDO_SENSE, 8'h00);
    rd(8'h0b, 8'h00);
    go(1'b1, 1'b0, ADDR_SOV_MASK, 8'h00);
    irq_is(1'b0);
    rd(ADDR_SOV_MASK, 8'hc1);
    go(1'b1, 1'b0, ADDR_SOV_STAT, 8'hfb);
    rd(ADDR_SOV_STAT, 8'h04);
    go(1'b1, 1'b0, ADDR_SOV_STAT, 8'hff);
    rd(ADDR_SOV_STAT, 8'h00);
    irq_is(1'b1);
    go(1'b1, 1'b0, ADDR_SOV_MASK, 8'hff);
    rd(ADDR_SOV_MASK, 8'hc5);
    go(1'b1, 1'b0, ADDR_BUCK_MASK, 8'h00);
    rd(ADDR_BUCK_MASK, 8'h66);
    go(1'b1, 1'b0, ADDR_BUCK_MASK, 8'hff);
    go(1'b1, 1'b0, ADDR_LDO_MASK, 8'hc0);
    rd(ADDR_LDO_MASK, 8'h00);
    go(1'b1, 1'b0, ADDR_LDO_MASK, 8'hff);
    go(1'b1, 1'b0, ADDR_LDO_SENSE, 8'hff);
    rd(ADDR_LDO_SENSE, 8'h00);
    for (int j = 0; j < 10; j++) begin
      a = (j < 6) ? ADDR_LDO_STAT : (j == 6) ? ADDR_SOV_STAT : ADDR_BUCK_STAT;
      b = (j < 6) ? 8'h01 << j : (j == 6) ? 8'h04 : (j == 7) ? 8'h01 : (j == 8) ? 8'h08 : 8'h10;
      rnd = lfsr(rnd);
      // Glitch shorter than either debounce count
      @(posedge clk) lvl[j] <= 1'b1;
      repeat (1 + rnd[0]) @(posedge clk);
      lvl[j] <= 1'b0;
      repeat (20) @(posedge clk);
      rd(a, 8'h00);
      lvl[j] <= 1'b1;
      repeat (OC + 12) @(posedge clk);
      rd(a, b);
      rd(a + 8'h02, b);
      irq_is(1'b1);
      go(1'b1, 1'b0, a, rnd & ~b);
      rd(a, b);
      go(1'b1, 1'b0, a + 8'h01, ~b);
      irq_is(1'b0);
      lvl[j] <= 1'b0;
      repeat (OC + 12) @(posedge clk);
      rd(a + 8'h02, 8'h00);
      go(1'b1, 1'b0, a, b);
      irq_is(1'b1);
      rd(a, 8'h00);
      go(1'b1, 1'b0, a + 8'h01, 8'hff);
    end
    // Second reset in mid-run restores defaults and resamples the strap
    repeat (3) @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    irq_is(1'b1);
    rd(ADDR_SOV_STAT, 8'h04);
    rd(ADDR_LDO_MASK, 8'h3f);
    repeat (3) @(posedge clk);
    report_and_stop();
  end
endmodule : regulator_fault_interrupt_bank_test
`default_nettype wire

// ==== rfib_bank.sv ====
// Regulator fault interrupt bank: latched flags, masks, live sense and the active-low interrupt pin.
// Assumes the serial bus decoder presents one-cycle read/write strobes on the device clock.
// Function
// - Buck status 0x08 latches overcurrent flags at bits 0,3,4; reset zero, write-one clears.
// - Buck mask 0x09 read/write at buck flag positions, resets to one.
// - Buck sense 0x0A read-only, one while the buck exceeds its current limit.
// - Bit 2 of 0x0E latches supply overvoltage; resets zero, write-one clears.
// - Supply overvoltage flag reads one by default when aux input grounded.
// - Bit 2 of mask 0x0F masks supply overvoltage; read/write, resets to one.
// - Bit 2 of sense 0x10 shows live supply overvoltage; resets zero.
// - Status 0x11 bits 0..5 latch linear regulator overcurrent flags, write-one clears.
// - Mask 0x12 bits 0..5 read/write, reset to one.
// - Sense 0x13 bits 0..5 show live linear regulator overcurrent.
// - Masked flags never pull the interrupt pin but stay readable.
// - A set flag drives the pin low at once when unmasked.
// - Sources set flags only after debounce: 8.0 ms overcurrent, 0.122 ms overvoltage.
`timescale 1ns/1ps
`default_nettype none
module rfib_bank
  import rfib_pkg::*;
#(
  parameter int unsigned OC_DEB = OC_DEB_CYC,
  parameter int unsigned SOV_DEB = SOV_DEB_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Fault comparator levels and power path strap
  input wire rfib_src_t fault_raw_i,
  input wire logic aux_supply_grounded_i,
  // Register port
  input wire rfib_req_t req_i,
  output logic [7:0] rdata_o,
  // Interrupt pin
  output logic irq_out_n
);
  rfib_src_t live;
  rfib_src_t rise;
  logic [7:0] buck_stat_q, buck_mask_q;
  logic [7:0] sov_stat_q, sov_mask_q;
  logic [7:0] ldo_stat_q, ldo_mask_q;
  logic [7:0] buck_live, buck_rise, sov_live, sov_rise, ldo_live, ldo_rise;
  logic [7:0] rdata_d, rdata_q;
  logic strap_done_q;
  logic irq_d;

  localparam logic [LDO_COUNT+3:0] OC_SEL = {3'h7, 1'b0, {LDO_COUNT{1'b1}}};
  genvar gi;
  generate
    for (gi = 0; gi < LDO_COUNT + 4; gi++) begin : g_src
      rfib_debounce #(.COUNT(OC_SEL[gi] ? OC_DEB : SOV_DEB)) u_deb (
        .clk(clk),
        .arst_n(arst_n),
        .raw_i(fault_raw_i[gi]),
        .live_o(live[gi]),
        .rise_o(rise[gi])
      );
    end
  endgenerate

  always_comb begin
    buck_live = 8'h00;
    buck_rise = 8'h00;
    buck_live[BUCK_ONE_BIT] = live.buck[0];
    buck_live[BUCK_TWO_BIT] = live.buck[1];
    buck_live[BUCK_THREE_BIT] = live.buck[2];
    buck_rise[BUCK_ONE_BIT] = rise.buck[0];
    buck_rise[BUCK_TWO_BIT] = rise.buck[1];
    buck_rise[BUCK_THREE_BIT] = rise.buck[2];
    sov_live = 8'h00;
    sov_rise = 8'h00;
    sov_live[SOV_BIT] = live.sov;
    sov_rise[SOV_BIT] = rise.sov;
    ldo_live = {2'h0, live.ldo};
    ldo_rise = {2'h0, rise.ldo};
  end

  wire wr_buck_stat = req_i.wr && req_i.addr == ADDR_BUCK_STAT;
  wire wr_sov_stat = req_i.wr && req_i.addr == ADDR_SOV_STAT;
  wire wr_ldo_stat = req_i.wr && req_i.addr == ADDR_LDO_STAT;

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      buck_stat_q <= BUCK_STAT_RST;
    end else begin
      buck_stat_q <= ((buck_stat_q & ~(wr_buck_stat ? req_i.wdata : 8'h00)) | buck_rise) & BUCK_FIELDS;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ldo_stat_q <= LDO_STAT_RST;
    end else begin
      ldo_stat_q <= ((ldo_stat_q & ~(wr_ldo_stat ? req_i.wdata : 8'h00)) | ldo_rise) & LDO_FIELDS;
    end
  end

  // Strap is sampled once after reset release, never under the asynchronous reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sov_stat_q <= SOV_STAT_RST;
      strap_done_q <= 1'b0;
    end else begin
      strap_done_q <= 1'b1;
      if (!strap_done_q && aux_supply_grounded_i) begin
        sov_stat_q <= SOV_FIELDS;
      end else begin
        sov_stat_q <= ((sov_stat_q & ~(wr_sov_stat ? req_i.wdata : 8'h00)) | sov_rise) & SOV_FIELDS;
      end
    end
  end

  // Unused mask bits keep their reset value: only documented R/W fields accept writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      buck_mask_q <= BUCK_MASK_RST;
      sov_mask_q <= SOV_MASK_RST;
      ldo_mask_q <= LDO_MASK_RST;
    end else if (req_i.wr) begin
      if (req_i.addr == ADDR_BUCK_MASK) begin
        buck_mask_q <= (buck_mask_q & ~BUCK_FIELDS) | (req_i.wdata & BUCK_FIELDS);
      end
      if (req_i.addr == ADDR_SOV_MASK) begin
        sov_mask_q <= (sov_mask_q & ~SOV_FIELDS) | (req_i.wdata & SOV_FIELDS);
      end
      if (req_i.addr == ADDR_LDO_MASK) begin
        ldo_mask_q <= (ldo_mask_q & ~LDO_FIELDS) | (req_i.wdata & LDO_FIELDS);
      end
    end
  end

  always_comb begin
    case (req_i.addr)
      ADDR_BUCK_STAT: rdata_d = buck_stat_q;
      ADDR_BUCK_MASK: rdata_d = buck_mask_q;
      ADDR_BUCK_SENSE: rdata_d = buck_live;
      ADDR_SOV_STAT: rdata_d = sov_stat_q;
      ADDR_SOV_MASK: rdata_d = sov_mask_q;
      ADDR_SOV_SENSE: rdata_d = sov_live;
      ADDR_LDO_STAT: rdata_d = ldo_stat_q;
      ADDR_LDO_MASK: rdata_d = ldo_mask_q;
      ADDR_LDO_SENSE: rdata_d = ldo_live;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_q <= 8'h00;
    end else if (req_i.rd) begin
      rdata_q <= rdata_d;
    end
  end
  assign rdata_o = rdata_q;

  // Combinational pin so an unmask acts in the same cycle the mask register changes
  always_comb begin
    irq_d = |(buck_stat_q & ~buck_mask_q & BUCK_FIELDS)
          | |(sov_stat_q & ~sov_mask_q & SOV_FIELDS)
          | |(ldo_stat_q & ~ldo_mask_q & LDO_FIELDS);
  end
  assign irq_out_n = ~irq_d;

  AST_MASKED_QUIET: assert property (@(posedge clk) disable iff (!arst_n)
    ((buck_mask_q & BUCK_FIELDS) == BUCK_FIELDS && sov_mask_q[SOV_BIT] && (ldo_mask_q & LDO_FIELDS) == LDO_FIELDS)
      |-> irq_out_n) else $error("Interrupt pin low with all masked");
  AST_UNMASK_FIRES: assert property (@(posedge clk) disable iff (!arst_n)
    (req_i.wr && req_i.addr == ADDR_LDO_MASK && !req_i.wdata[0] && ldo_stat_q[0] && !wr_ldo_stat)
      |=> !irq_out_n) else $error("Pin not low after unmasking a set flag");
  AST_BUCK_W1C: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_buck_stat && req_i.wdata[BUCK_ONE_BIT] && !buck_rise[BUCK_ONE_BIT]) |=> !buck_stat_q[BUCK_ONE_BIT])
    else $error("Buck flag not cleared by write one");
  AST_BUCK_SET: assert property (@(posedge clk) disable iff (!arst_n)
    buck_rise[BUCK_TWO_BIT] |=> buck_stat_q[BUCK_TWO_BIT]) else $error("Buck flag not set on fault");
  AST_BUCK_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
    (buck_stat_q[BUCK_THREE_BIT] && !wr_buck_stat) |=> buck_stat_q[BUCK_THREE_BIT])
    else $error("Buck flag lost without clear");
  AST_SOV_W1C: assert property (@(posedge clk) disable iff (!arst_n)
    (strap_done_q && wr_sov_stat && req_i.wdata[SOV_BIT] && !sov_rise[SOV_BIT]) |=> !sov_stat_q[SOV_BIT])
    else $error("Overvoltage flag not cleared");
  AST_LDO_SET: assert property (@(posedge clk) disable iff (!arst_n)
    ldo_rise[5] |=> ldo_stat_q[5]) else $error("Linear regulator flag not set");
  AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (!arst_n)
    ##1 ((buck_stat_q & ~BUCK_FIELDS) == 8'h00 && (ldo_mask_q & ~LDO_FIELDS) == 8'h00))
    else $error("Unused bits changed");
  AST_MASK_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
    (req_i.wr && req_i.addr == ADDR_LDO_MASK) |=> ldo_mask_q == ($past(req_i.wdata) & LDO_FIELDS))
    else $error("Linear regulator mask not written");
  AST_SENSE_READ: assert property (@(posedge clk) disable iff (!arst_n)
    (req_i.rd && req_i.addr == ADDR_BUCK_SENSE) |=> rdata_o == $past(buck_live))
    else $error("Buck sense read wrong");
  AST_BUCK_MASK_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
    (req_i.wr && req_i.addr == ADDR_BUCK_MASK)
      |=> buck_mask_q == (($past(req_i.wdata) & BUCK_FIELDS) | (BUCK_MASK_RST & ~BUCK_FIELDS)))
    else $error("Buck mask not written");
  AST_SOV_MASK_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
    (req_i.wr && req_i.addr == ADDR_SOV_MASK)
      |=> sov_mask_q == (($past(req_i.wdata) & SOV_FIELDS) | (SOV_MASK_RST & ~SOV_FIELDS)))
    else $error("Overvoltage mask not written");
  AST_SOV_SET: assert property (@(posedge clk) disable iff (!arst_n)
    sov_rise[SOV_BIT] |=> sov_stat_q[SOV_BIT]) else $error("Overvoltage flag not set");
  AST_STRAP_DEFAULT: assert property (@(posedge clk) disable iff (!arst_n)
    (!strap_done_q && aux_supply_grounded_i) |=> sov_stat_q[SOV_BIT])
    else $error("Overvoltage default not applied");
  AST_LDO_W1C: assert property (@(posedge clk) disable iff (!arst_n)
    (wr_ldo_stat && req_i.wdata[2] && !ldo_rise[2]) |=> !ldo_stat_q[2])
    else $error("Linear regulator flag not cleared");
  AST_LDO_NO_SPURIOUS: assert property (@(posedge clk) disable iff (!arst_n)
    (!ldo_stat_q[0] && !ldo_rise[0]) |=> !ldo_stat_q[0])
    else $error("Linear regulator flag set without fault");
  AST_SOV_SENSE_READ: assert property (@(posedge clk) disable iff (!arst_n)
    (req_i.rd && req_i.addr == ADDR_SOV_SENSE) |=> rdata_o == $past(sov_live))
    else $error("Overvoltage sense read wrong");
  AST_LDO_SENSE_READ: assert property (@(posedge clk) disable iff (!arst_n)
    (req_i.rd && req_i.addr == ADDR_LDO_SENSE) |=> rdata_o == $past(ldo_live))
    else $error("Linear regulator sense read wrong");
  AST_RISE_LIVE: assert property (@(posedge clk) disable iff (!arst_n)
    rise.sov |=> live.sov) else $error("Overvoltage rise without filtered level");
endmodule : rfib_bank
`default_nettype wire

// ==== rfib_debounce.sv ====
// Debounce filter for one fault source: three-flop sync then stability counter.
// Assumes an asynchronous analog comparator level on raw_i.
`timescale 1ns/1ps
`default_nettype none
module rfib_debounce #(
  parameter int unsigned COUNT = 160000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Source
  input wire logic raw_i,
  // Filtered outputs
  output logic live_o,
  output logic rise_o
);
  localparam int W = $clog2(COUNT + 1);
  logic [2:0] sync_q;
  logic [W-1:0] cnt_q;
  logic live_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= {sync_q[1:0], raw_i};
    end
  end

  // Counter restarts whenever the synchronised level is unsettled or agrees with the filtered one
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
      live_q <= 1'b0;
    end else if (sync_q[2] != sync_q[1] || sync_q[2] == live_q) begin
      cnt_q <= '0;
    end else if (cnt_q == W'(COUNT - 1)) begin
      cnt_q <= '0;
      live_q <= sync_q[2];
    end else begin
      cnt_q <= cnt_q + W'(1);
    end
  end

  assign live_o = live_q;
  assign rise_o = (sync_q[2] == sync_q[1]) && sync_q[2] && !live_q && (cnt_q == W'(COUNT - 1));
endmodule : rfib_debounce
`default_nettype wire

// ==== rfib_fault_src.sv ====
// Partner model: regulator current and supply voltage comparators feeding the fault bank.
// Assumes the bench commands ideal fault levels; outputs are asynchronous to the device clock.
`timescale 1ns/1ps
`default_nettype none
module rfib_fault_src
  import rfib_pkg::*;
(
  // Commanded levels
  input wire rfib_src_t level_i,
  // Comparator outputs
  output wire rfib_src_t fault_raw_o
);
  // Analog path is unclocked, so edges land mid-cycle
  assign #7 fault_raw_o = level_i;
endmodule : rfib_fault_src
`default_nettype wire

// ==== rfib_pkg.sv ====
// Regulator fault interrupt bank: register map, field positions, reset values, debounce timing.
// Assumes an internal 20 MHz clock and an 8-bit register port from the serial control bus decoder.
package rfib_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam logic [7:0] ADDR_BUCK_STAT = 8'h08;
  localparam logic [7:0] ADDR_BUCK_MASK = 8'h09;
  localparam logic [7:0] ADDR_BUCK_SENSE = 8'h0a;
  localparam logic [7:0] ADDR_SOV_STAT = 8'h0e;
  localparam logic [7:0] ADDR_SOV_MASK = 8'h0f;
  localparam logic [7:0] ADDR_SOV_SENSE = 8'h10;
  localparam logic [7:0] ADDR_LDO_STAT = 8'h11;
  localparam logic [7:0] ADDR_LDO_MASK = 8'h12;
  localparam logic [7:0] ADDR_LDO_SENSE = 8'h13;
  // Field positions
  localparam int BUCK_ONE_BIT = 0;
  localparam int BUCK_TWO_BIT = 3;
  localparam int BUCK_THREE_BIT = 4;
  localparam int SOV_BIT = 2;
  localparam int LDO_COUNT = 6;
  // Bits that hold a function in each register
  localparam logic [7:0] BUCK_FIELDS = 8'h19;
  localparam logic [7:0] SOV_FIELDS = 8'h04;
  localparam logic [7:0] LDO_FIELDS = 8'h3f;
  // Reset values (mask registers: function bits reset to one, unused bits to fixed values)
  localparam logic [7:0] BUCK_STAT_RST = 8'h00;
  localparam logic [7:0] BUCK_MASK_RST = 8'h7f;
  localparam logic [7:0] SOV_STAT_RST = 8'h00;
  localparam logic [7:0] SOV_MASK_RST = 8'hc5;
  localparam logic [7:0] LDO_STAT_RST = 8'h00;
  localparam logic [7:0] LDO_MASK_RST = 8'h3f;
  // Debounce times: overcurrent in microseconds, overvoltage in nanoseconds
  localparam int unsigned OC_DEB_US = 8000;
  localparam int unsigned SOV_DEB_NS = 122000;
  localparam int unsigned OC_DEB_CYC = (CLK_HZ / 1000000) * OC_DEB_US;
  localparam int unsigned SOV_DEB_CYC = (CLK_HZ / 1000) * SOV_DEB_NS / 1000000;

  typedef struct packed {
    logic [2:0] buck;
    logic sov;
    logic [LDO_COUNT-1:0] ldo;
  } rfib_src_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rfib_req_t;
endpackage : rfib_pkg
